// ==== rtl/sop_cdc_word.sv ====
module sop_cdc_word #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic rst_n,
  input wire logic src_load,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  output logic [W-1:0] dst_data
);
  logic [W-1:0] hold, next_hold, next_dst_data;
  logic req, next_req, pend, next_pend, ack_s, req_s, req_d, ack;
  logic send;

  // source side: hold word steady until the toggle is returned
  assign src_busy = req ^ ack_s;
  assign send = (src_load | pend) & ~src_busy;

  always_comb begin
    next_hold = send ? src_data : hold;
    next_req = send ? ~req : req;
    next_pend = (pend | src_load) & ~send;
  end

  always_ff @(posedge src_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= RST_VAL;
      req <= 1'b0;
      pend <= 1'b0;
    end else begin
      hold <= next_hold;
      req <= next_req;
      pend <= next_pend;
    end
  end

  sop_sync2 #(.W(1)) u_ack (.clk(src_clk), .rst_n(rst_n), .d(ack),
    .q(ack_s));
  sop_sync2 #(.W(1)) u_req (.clk(dst_clk), .rst_n(rst_n), .d(req),
    .q(req_s));

  always_comb begin
    next_dst_data = (req_s ^ req_d) ? hold : dst_data;
  end

  always_ff @(posedge dst_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_d <= 1'b0;
      ack <= 1'b0;
      dst_data <= RST_VAL;
    end else begin
      req_d <= req_s;
      ack <= req_s;
      dst_data <= next_dst_data;
    end
  end
endmodule

// ==== rtl/sop_pkg.sv ====
package sop_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_HS = 8'h00;
  localparam logic [7:0] REG_VS = 8'h04;
  localparam logic [7:0] REG_SLC = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  // field positions in the software words
  localparam int HS_OUT_POL = 0;
  localparam int HS_IN_POL = 1;
  localparam int HS_W_LSB = 8;
  localparam int VS_SRC = 0;
  localparam int VS_POL = 1;
  localparam int VS_WEN = 2;
  localparam int VS_W_LSB = 8;
  localparam int SLC_LSB = 0;
  localparam int ST_STRAP = 0;
  localparam int ST_FIELD = 1;
  localparam int ST_VSYNC = 2;
  localparam int ST_BUSY = 3;
  // values after reset
  localparam logic HS_OUT_POL_RST = 1'b1;
  localparam logic HS_IN_POL_RST = 1'b0;
  localparam logic [7:0] HS_W_RST = 8'h20;
  localparam logic VS_SRC_RST = 1'b0;
  localparam logic VS_POL_RST = 1'b0;
  localparam logic VS_WEN_RST = 1'b0;
  localparam logic [7:0] VS_W_RST = 8'h04;
  localparam logic [1:0] SLC_RST = 2'h0;
  // slicer source codes
  localparam logic [1:0] SLC_GREEN = 2'h0;
  localparam logic [1:0] SLC_RAW_HS = 2'h1;
  localparam logic [1:0] SLC_REGEN = 2'h2;
  localparam logic [1:0] SLC_PLL_FILTER_NODE = 2'h3;
  // config word carried into the pixel domain
  localparam int C_HS_OP = 0;
  localparam int C_HS_IP = 1;
  localparam int C_HS_W = 2;
  localparam int C_VS_SRC = 10;
  localparam int C_VS_POL = 11;
  localparam int C_VS_WEN = 12;
  localparam int C_VS_W = 13;
  localparam int C_SEL = 21;
  localparam int CFG_W = 23;
  localparam logic [CFG_W-1:0] CFG_RST = {SLC_RST, VS_W_RST, VS_WEN_RST,
    VS_POL_RST, VS_SRC_RST, HS_W_RST, HS_IN_POL_RST, HS_OUT_POL_RST};
  // cycles
  localparam logic [3:0] STRAP_WAIT_CYC = 4'h8;
  localparam int PIX_PIPE = 4;
  // upper bits of the serial slave address, arbitrary value
  localparam logic [5:0] DEV_ADDR_HI = 6'h26;
endpackage

// ==== rtl/sop_sync2.sv ====
module sop_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== rtl/sop_top.sv ====
// Functional notes
// - rebuild hsync, retimed to pixel clock
// - hsync polarity and width programmable
// - hsync aligned with data clock, colours
// - vsync from composite separator or pass-through
// - vsync polarity bit inverts output
// - strap gives serial address lsb
// - strap sampled at power-up, pulled up
// - shared pin: strap kept while vsync toggles
// - slicer output from four sources
// - slicer output otherwise unprocessed
// - field output marks odd or even
// - configuration via serial slave address; here registers are written over APB and i2c_dev_addr is only an output
// - hsync leading edge set by polarity
//
// The register offsets and register access over APB were left to the implementer.
module sop_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sop_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [6:0] i2c_dev_addr,
  input wire logic pix_clk,
  input wire logic horiz_sync_in,
  input wire logic vsync_in,
  input wire logic csync_vsync_in,
  input wire logic green_sync_in,
  input wire logic pll_filter_node_regen_hsync_in,
  input wire logic pll_filter_node_hsync_in,
  input wire logic [9:0] red_in,
  input wire logic [9:0] green_in,
  input wire logic [9:0] blue_in,
  output logic [9:0] red_out,
  output logic [9:0] green_out,
  output logic [9:0] blue_out,
  output logic regen_hsync_out,
  output logic pixel_data_clock_out,
  input wire logic address_lsb_strap,
  output logic vertical_sync_out,
  output logic vertical_sync_oe,
  output logic slicer_out,
  output logic field_out
);
  import sop_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic hs_op, hs_ip, vs_src, vs_pol, vs_wen;
  logic next_hs_op, next_hs_ip, next_vs_src, next_vs_pol, next_vs_wen;
  logic [7:0] hs_w, vs_w, next_hs_w, next_vs_w;
  logic [1:0] slc, next_slc;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, cfg_load, next_cfg_load, cfg_busy;
  logic setup, acc_wr;
  logic [1:0] stat_s;

  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pready & pwrite;

  always_comb begin
    next_hs_op = hs_op;
    next_hs_ip = hs_ip;
    next_hs_w = hs_w;
    next_vs_src = vs_src;
    next_vs_pol = vs_pol;
    next_vs_wen = vs_wen;
    next_vs_w = vs_w;
    next_slc = slc;
    next_cfg_load = 1'b0;
    next_prdata = '0;
    next_pslverr = 1'b0;
    next_pready = setup;
    if (acc_wr && !pslverr) begin
      case (paddr)
        REG_HS: begin
          next_hs_op = pwdata[HS_OUT_POL];
          next_hs_ip = pwdata[HS_IN_POL];
          next_hs_w = pwdata[HS_W_LSB +: 8];
          next_cfg_load = 1'b1;
        end
        REG_VS: begin
          next_vs_src = pwdata[VS_SRC];
          next_vs_pol = pwdata[VS_POL];
          next_vs_wen = pwdata[VS_WEN];
          next_vs_w = pwdata[VS_W_LSB +: 8];
          next_cfg_load = 1'b1;
        end
        REG_SLC: begin
          next_slc = pwdata[SLC_LSB +: 2];
          next_cfg_load = 1'b1;
        end
        default: ;
      endcase
    end
    if (setup) begin
      case (paddr)
        REG_HS: begin
          next_prdata[HS_OUT_POL] = hs_op;
          next_prdata[HS_IN_POL] = hs_ip;
          next_prdata[HS_W_LSB +: 8] = hs_w;
        end
        REG_VS: begin
          next_prdata[VS_SRC] = vs_src;
          next_prdata[VS_POL] = vs_pol;
          next_prdata[VS_WEN] = vs_wen;
          next_prdata[VS_W_LSB +: 8] = vs_w;
        end
        REG_SLC: next_prdata[SLC_LSB +: 2] = slc;
        REG_STAT: begin
          next_prdata[ST_STRAP] = i2c_dev_addr[0];
          next_prdata[ST_FIELD] = stat_s[0];
          next_prdata[ST_VSYNC] = stat_s[1];
          next_prdata[ST_BUSY] = cfg_busy;
        end
        default: next_pslverr = 1'b1;
      endcase
    end else if (psel) begin
      next_prdata = prdata;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_op <= HS_OUT_POL_RST;
      hs_ip <= HS_IN_POL_RST;
      hs_w <= HS_W_RST;
      vs_src <= VS_SRC_RST;
      vs_pol <= VS_POL_RST;
      vs_wen <= VS_WEN_RST;
      vs_w <= VS_W_RST;
      slc <= SLC_RST;
      cfg_load <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      hs_op <= next_hs_op;
      hs_ip <= next_hs_ip;
      hs_w <= next_hs_w;
      vs_src <= next_vs_src;
      vs_pol <= next_vs_pol;
      vs_wen <= next_vs_wen;
      vs_w <= next_vs_w;
      slc <= next_slc;
      cfg_load <= next_cfg_load;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address strap on the shared vsync pin
  logic strap_s, strap_done, next_strap_done;
  logic [3:0] strap_cnt, next_strap_cnt;
  logic [6:0] next_dev_addr;

  sop_sync2 #(.W(1)) u_strap_sync (.clk(pclk), .rst_n(presetn),
    .d(address_lsb_strap), .q(strap_s));

  always_comb begin
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_dev_addr = i2c_dev_addr;
    if (!strap_done) begin
      next_strap_cnt = strap_cnt + 4'h1;
      if (strap_cnt == STRAP_WAIT_CYC) begin
        next_strap_done = 1'b1;
        next_dev_addr = {DEV_ADDR_HI, strap_s};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt <= '0;
      strap_done <= 1'b0;
      i2c_dev_addr <= '0;
    end else begin
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      i2c_dev_addr <= next_dev_addr;
    end
  end

  a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done |=> $stable(i2c_dev_addr))
    else $error("address changed after strap capture");

  ////////////////////////////////////////////////////////////////////////
  // pixel domain
  logic [CFG_W-1:0] cfg;
  logic hs_s, vs_s, cs_s, gs_s, fr_s, fh_s, strap_done_s;
  logic hs_act, hs_s_d, hs_lead, vs_in_sel, vs_src_d, vs_lead, vs_act;
  logic [7:0] hs_cnt, next_hs_cnt, vs_cnt, next_vs_cnt;
  logic [11:0] hpos, next_hpos, line_len, next_line_len;
  logic next_regen, next_vs_out, next_slicer, next_field;
  logic [29:0] pipe [PIX_PIPE];
  logic [29:0] next_pipe [PIX_PIPE];

  sop_cdc_word #(.W(CFG_W), .RST_VAL(CFG_RST)) u_cfg_cdc (
    .src_clk(pclk), .dst_clk(pix_clk), .rst_n(presetn),
    .src_load(cfg_load),
    .src_data({slc, vs_w, vs_wen, vs_pol, vs_src, hs_w, hs_ip, hs_op}),
    .src_busy(cfg_busy), .dst_data(cfg));

  sop_sync2 #(.W(7)) u_pin_sync (.clk(pix_clk), .rst_n(presetn),
    .d({horiz_sync_in, vsync_in, csync_vsync_in, green_sync_in,
      pll_filter_node_regen_hsync_in, pll_filter_node_hsync_in, strap_done}),
    .q({hs_s, vs_s, cs_s, gs_s, fr_s, fh_s, strap_done_s}));

  sop_sync2 #(.W(2)) u_stat_sync (.clk(pclk), .rst_n(presetn),
    .d({field_out, vertical_sync_out}), .q(stat_s));

  assign hs_act = cfg[C_HS_IP] ? hs_s : ~hs_s;
  // edge of the synced level itself: no false lead after reset or on
  // a polarity change
  assign hs_lead = hs_act & (cfg[C_HS_IP] ? ~hs_s_d : hs_s_d);
  assign vs_in_sel = cfg[C_VS_SRC] ? cs_s : vs_s;
  assign vs_lead = vs_in_sel & ~vs_src_d;
  assign vs_act = cfg[C_VS_WEN] ? (vs_cnt != 8'h00) : vs_in_sel;

  always_comb begin
    next_hs_cnt = hs_cnt;
    if (hs_lead) begin
      next_hs_cnt = cfg[C_HS_W +: 8];
    end else if (hs_cnt != 8'h00) begin
      next_hs_cnt = hs_cnt - 8'h01;
    end
    next_regen = (hs_cnt != 8'h00) ~^ cfg[C_HS_OP];
    next_vs_cnt = vs_cnt;
    if (vs_lead && cfg[C_VS_WEN]) begin
      next_vs_cnt = cfg[C_VS_W +: 8];
    end else if (vs_cnt != 8'h00) begin
      next_vs_cnt = vs_cnt - 8'h01;
    end
    next_vs_out = vs_act ^ cfg[C_VS_POL];
    // field from vsync position in line
    next_hpos = hs_lead ? 12'h000 : hpos + 12'h001;
    next_line_len = hs_lead ? hpos : line_len;
    next_field = vs_lead ? (hpos >= {1'b0, line_len[11:1]}) : field_out;
    case (cfg[C_SEL +: 2])
      SLC_GREEN: next_slicer = gs_s;
      SLC_RAW_HS: next_slicer = hs_s;
      SLC_REGEN: next_slicer = fr_s;
      SLC_PLL_FILTER_NODE: next_slicer = fh_s;
      default: next_slicer = gs_s;
    endcase
    // data delayed to match hsync path
    next_pipe[0] = {red_in, green_in, blue_in};
    for (int i = 1; i < PIX_PIPE; i++) begin
      next_pipe[i] = pipe[i-1];
    end
  end

  always_ff @(posedge pix_clk or negedge presetn) begin
    if (!presetn) begin
      hs_s_d <= 1'b0;
      hs_cnt <= '0;
      vs_src_d <= 1'b0;
      vs_cnt <= '0;
      hpos <= '0;
      line_len <= '0;
      regen_hsync_out <= 1'b0;
      vertical_sync_out <= 1'b0;
      vertical_sync_oe <= 1'b0;
      slicer_out <= 1'b0;
      field_out <= 1'b0;
      pixel_data_clock_out <= 1'b0;
      for (int i = 0; i < PIX_PIPE; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      hs_s_d <= hs_s;
      hs_cnt <= next_hs_cnt;
      vs_src_d <= vs_in_sel;
      vs_cnt <= next_vs_cnt;
      hpos <= next_hpos;
      line_len <= next_line_len;
      regen_hsync_out <= next_regen;
      vertical_sync_out <= next_vs_out;
      // drive pin only after strap capture
      vertical_sync_oe <= strap_done_s;
      slicer_out <= next_slicer;
      field_out <= next_field;
      pixel_data_clock_out <= ~pixel_data_clock_out;
      pipe <= next_pipe;
    end
  end

  assign {red_out, green_out, blue_out} = pipe[PIX_PIPE-1];

  ////////////////////////////////////////////////////////////////////////
  a_hs_lead_edge: assert property (@(posedge pix_clk)
    disable iff (!presetn) (!cfg[C_HS_IP] && $fell(hs_s)) |-> hs_lead)
    else $error("falling hsync not taken as leading edge");
  a_hs_width_load: assert property (@(posedge pix_clk)
    disable iff (!presetn) hs_lead |=> hs_cnt == $past(cfg[C_HS_W +: 8]))
    else $error("hsync width not loaded at leading edge");
  a_hs_width_count: assert property (@(posedge pix_clk)
    disable iff (!presetn) (!hs_lead && hs_cnt != 8'h00)
    |=> hs_cnt == $past(hs_cnt) - 8'h01)
    else $error("hsync width count not decrementing");
  a_hs_out_level: assert property (@(posedge pix_clk)
    disable iff (!presetn) hs_cnt != 8'h00
    |=> regen_hsync_out == $past(cfg[C_HS_OP]))
    else $error("regenerated hsync not at active level");
  a_data_align: assert property (@(posedge pix_clk)
    disable iff (!presetn) hs_lead |-> ##2 red_out == $past(red_in, 4))
    else $error("pixel data out of step with hsync");
  a_vs_pass: assert property (@(posedge pix_clk)
    disable iff (!presetn) (!cfg[C_VS_WEN] && !cfg[C_VS_POL]
    && !cfg[C_VS_SRC]) |=> vertical_sync_out == $past(vs_s))
    else $error("vsync pass-through broken");
  a_vs_invert: assert property (@(posedge pix_clk)
    disable iff (!presetn) (!cfg[C_VS_WEN] && cfg[C_VS_POL]
    && cfg[C_VS_SRC]) |=> vertical_sync_out == !$past(cs_s))
    else $error("vsync polarity not applied");
  a_vs_width: assert property (@(posedge pix_clk)
    disable iff (!presetn) (vs_lead && cfg[C_VS_WEN])
    |=> vs_cnt == $past(cfg[C_VS_W +: 8]))
    else $error("programmed vsync width not loaded");
  a_slicer_hs: assert property (@(posedge pix_clk)
    disable iff (!presetn) cfg[C_SEL +: 2] == SLC_RAW_HS
    |=> slicer_out == $past(hs_s))
    else $error("slicer raw hsync source wrong");
  a_strap_oe: assert property (@(posedge pix_clk)
    disable iff (!presetn) !strap_done_s |=> !vertical_sync_oe)
    else $error("shared pin driven before strap capture");
endmodule

// ==== testbench/sop_display_model.sv ====
module sop_display_model (
  input wire logic pix_clk,
  input wire logic presetn,
  input wire logic regen_hsync_out,
  input wire logic hs_act,
  input wire logic vertical_sync_out,
  input wire logic vertical_sync_oe,
  input wire logic strap_pull,
  output logic pin_level,
  output logic [7:0] hs_width,
  output logic [7:0] vs_width
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hs_cnt;
  logic [7:0] vs_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // pulled up while released
  assign pin_level = vertical_sync_oe ? vertical_sync_out : strap_pull;
  ////////////////////////////////////////////////////////////////////////////
  // active widths seen downstream
  always_ff @(posedge pix_clk or negedge presetn) begin
    if (!presetn) begin
      hs_cnt <= 8'h00;
      vs_cnt <= 8'h00;
      hs_width <= 8'h00;
      vs_width <= 8'h00;
    end else begin
      if (regen_hsync_out === hs_act) begin
        hs_cnt <= hs_cnt + 8'h01;
      end else if (hs_cnt != 8'h00) begin
        hs_width <= hs_cnt;
        hs_cnt <= 8'h00;
      end
      if (vertical_sync_out === 1'b1) begin
        vs_cnt <= vs_cnt + 8'h01;
      end else if (vs_cnt != 8'h00) begin
        vs_width <= vs_cnt;
        vs_cnt <= 8'h00;
      end
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sop_pkg::*;
  logic pclk = 1'b0;
  logic pix_clk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, p;
  logic [6:0] i2c_dev_addr;
  logic vsync_in = 1'b0;
  logic csync_vsync_in = 1'b0;
  logic [3:0] src = 4'h2;
  logic [9:0] red_in = 10'h0;
  logic [9:0] green_in = 10'h0;
  logic [9:0] blue_in = 10'h0;
  logic [9:0] red_out, green_out, blue_out;
  logic regen_hsync_out, pixel_data_clock_out, pin_level;
  logic vertical_sync_out, vertical_sync_oe, slicer_out, field_out;
  logic hs_act = 1'b1;
  logic [7:0] hs_width, vs_width;
  int miscompares = 0;
  int checked = 0;
  int hl, dl, k;
  wire green_sync_in = src[0];
  wire horiz_sync_in = src[1];
  wire pll_filter_node_regen_hsync_in = src[2];
  wire pll_filter_node_hsync_in = src[3];

  always #5 pclk = ~pclk;
  always #62.5 pix_clk = ~pix_clk;

  sop_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .i2c_dev_addr, .pix_clk, .horiz_sync_in,
    .vsync_in, .csync_vsync_in, .green_sync_in, .pll_filter_node_regen_hsync_in,
    .pll_filter_node_hsync_in, .red_in, .green_in, .blue_in, .red_out, .green_out,
    .blue_out, .regen_hsync_out, .pixel_data_clock_out,
    .address_lsb_strap(pin_level), .vertical_sync_out, .vertical_sync_oe,
    .slicer_out, .field_out);

  sop_display_model model (.pix_clk, .presetn, .regen_hsync_out, .hs_act,
    .vertical_sync_out, .vertical_sync_oe, .strap_pull(1'b1), .pin_level,
    .hs_width, .vs_width);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pix(input int n);
    repeat (n) @(posedge pix_clk);
  endtask

  // write, then wait until the word has crossed to the pixel side
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    int n;
    apb(1'b1, a, d);
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) miscompares++;
    pix(8);
  endtask

  // one line of 40 pixel clocks, hsync rising at its start; composite
  // vsync rises at vs_at when that is nonzero
  task automatic line(input int vs_at);
    src[1] <= 1'b1;
    csync_vsync_in <= 1'b0;
    for (int i = 1; i < 40; i++) begin
      @(posedge pix_clk);
      if (i == 4) src[1] <= 1'b0;
      if (i == vs_at) csync_vsync_in <= 1'b1;
    end
    @(posedge pix_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500us;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(i2c_dev_addr, {DEV_ADDR_HI, 1'b1});
    rdchk(REG_HS,
      {16'h0, HS_W_RST, 6'h0, HS_IN_POL_RST, HS_OUT_POL_RST});
    rdchk(REG_VS, {16'h0, VS_W_RST, 8'h0});
    rdchk(REG_SLC, 32'h0);
    apb(1'b1, REG_STAT, 32'hf);
    rdchk(REG_STAT, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // hsync and pixel data out after the same number of pixel clocks
    cfg(REG_HS, 32'h0501);
    @(posedge pix_clk);
    src[1] <= 1'b0;
    red_in <= 10'h155;
    green_in <= 10'h0aa;
    blue_in <= 10'h3c3;
    hl = 0;
    dl = 0;
    for (k = 1; k <= 12; k++) begin
      @(posedge pix_clk);
      #1;
      if (hl == 0 && regen_hsync_out === 1'b1) hl = k;
      if (dl == 0 && blue_out === 10'h3c3) dl = k;
    end
    chk(dl, PIX_PIPE);
    chk(hl, dl);
    chk({red_out, green_out}, {10'h155, 10'h0aa});
    src[1] <= 1'b1;
    pix(4);
    chk(hs_width, 8'h05);
    cfg(REG_HS, 32'h0302);
    hs_act <= 1'b0;
    src[1] <= 1'b0;
    pix(6);
    chk(regen_hsync_out, 1'b1);
    src[1] <= 1'b1;
    pix(12);
    chk(hs_width, 8'h03);
    @(posedge pix_clk);
    #1;
    p = pixel_data_clock_out;
    @(posedge pix_clk);
    #1;
    chk(p ^ pixel_data_clock_out, 1'b1);
    // vertical sync sources, polarity and width
    vsync_in <= 1'b1;
    pix(6);
    chk(vertical_sync_out, 1'b1);
    cfg(REG_VS, 32'h2);
    chk(vertical_sync_out, 1'b0);
    cfg(REG_VS, 32'h1);
    chk(vertical_sync_out, 1'b0);
    csync_vsync_in <= 1'b1;
    pix(6);
    chk(vertical_sync_out, 1'b1);
    apb(1'b0, REG_STAT, 32'h0);
    chk({rd[ST_VSYNC], rd[ST_STRAP]}, 2'b11);
    chk({vertical_sync_oe, i2c_dev_addr}, {1'b1, DEV_ADDR_HI, 1'b1});
    cfg(REG_VS, 32'h3);
    chk(vertical_sync_out, 1'b0);
    csync_vsync_in <= 1'b0;
    cfg(REG_VS, 32'h0305);
    csync_vsync_in <= 1'b1;
    pix(20);
    chk(vs_width, 8'h03);
    // every slicer source, selected and deselected
    for (k = 0; k < 4; k++) begin
      cfg(REG_SLC, k);
      src <= 4'h1 << k;
      pix(6);
      chk(slicer_out, 1'b1);
      src <= ~(4'h1 << k);
      pix(6);
      chk(slicer_out, 1'b0);
    end
    // field: vsync late in a line, then early in the next
    line(0);
    line(0);
    line(30);
    chk(field_out, 1'b1);
    line(5);
    chk(field_out, 1'b0);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd[ST_FIELD], 1'b0);
    stop_test();
  end
endmodule
